// ### pwm_three_phase.sv
// three-phase center-based pwm controller with axi4-lite registers.
// assumes aclk is the instruction-rate clock and inputs are synchronous,
// except the trip paths, which clear the outputs without the clock.
//
// Functional notes
// [R01] six active-high outputs in three high/low complementary pairs
// [R02] period, dead time, min pulse width come from their registers
// [R03] one duty register per phase sets that pair's duty
// [R04] each output has an enable bit; cleared holds it inactive
// [R05] crossover bit per pair swaps high and low timing signals
// [R06] 8-bit chop field sets chopping frequency mixed into outputs
// [R07] chopping enabled separately for high side and low side
// [R08] single update: new values load once per period at its start
// [R09] double update: values also load at period midpoint
// [R10] a mode control bit selects single or double update
// [R11] mode bit 6: clear single, set double, clear after reset
// [R12] sync pulse each period start, also midpoint in double mode
// [R13] sync pulse width programmable through its own register
// [R14] sync pulse lasts width+1 clocks; width resets to 0x27
// [R15] period value is clocks in half a switching period
// [R16] trip input low forces all outputs off at once
// [R17] over-current from sense comparator also shuts outputs down
// [R18] hardware shutdown paths work without the clock
// [R19] software write to shutdown register shuts outputs down
// [R20] status shows trip input level and half-period flag
// [R21] half flag bit 3 clear first half, set second half
// [R22] timing unit makes complementary center pairs with dead time
// [R23] any shutdown source merged and resets the timing unit
// [R24] controller counters run at the instruction clock rate
// [R25] interrupt on each sync pulse and on any shutdown
// [R26] shutdown holds until source gone and software restarts
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module pwm_three_phase #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // shutdown inputs
  input  wire logic              trip_in_n,
  input  wire logic              current_sense_in,
  // gate drive outputs
  output logic                   phase_a_high_out,
  output logic                   phase_a_low_out,
  output logic                   phase_b_high_out,
  output logic                   phase_b_low_out,
  output logic                   phase_c_high_out,
  output logic                   phase_c_low_out,
  // converter sync and interrupt requests
  output logic                   period_sync_pulse,
  output logic                   sync_irq,
  output logic                   shutdown_irq
);

  localparam int CW = pwm_ctrl_pkg::CNT_W;
  localparam int DW = pwm_ctrl_pkg::DT_W;
  localparam int SW = pwm_ctrl_pkg::SW_W;

  // ==========================================================
  // state types
  typedef enum logic [0:0] {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } dir_t;

  // ==========================================================
  // declarations
  logic [CW-1:0] half_period_count;
  logic [DW-1:0] dead_time_count;
  logic [CW-1:0] pulse_deletion_count;
  logic [SW-1:0] sync_width_count;
  logic [CW-1:0] duty_phase_a;
  logic [CW-1:0] duty_phase_b;
  logic [CW-1:0] duty_phase_c;
  logic [8:0]    segment_control;
  logic [9:0]    gate_chop_control;
  logic [7:0]    mode_control_reg;
  logic [CW-1:0] tm_s;
  logic [DW-1:0] dt_s;
  logic [CW-1:0] pd_s;
  logic [SW-1:0] sw_s;
  logic [CW-1:0] duty_s [3];
  logic [8:0]    seg_s;
  logic [CW-1:0] cnt;
  dir_t          dir;
  logic [SW-1:0] sync_left;
  logic [7:0]    chop_cnt;
  logic          chop;
  logic          shut;
  logic          shut_q;
  logic          hw_trip;
  logic          soft_shut_wr;
  logic          restart_wr;
  logic          start_evt;
  logic          mid_evt;
  logic          load_evt;
  logic          sync_evt;
  logic          dbl;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          wr_go;
  logic [5:0]    pwm_raw;
  logic [5:0]    next_out;
  logic [2:0]    hi_t;
  logic [2:0]    lo_t;

  // merge byte lanes of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ==========================================================
  // axi4-lite write channels
  // address and data are taken in either order, then committed
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr       <= '0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      s_axi_awready <= 1'b0;
      aw_addr       <= s_axi_awaddr;
    end else if (wr_go) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data       <= '0;
      w_strb       <= '0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      s_axi_wready <= 1'b0;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (wr_go) begin
      s_axi_wready <= 1'b1;
    end
  end

  // response: the read-only status offset and offsets above restart answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pwm_ctrl_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      case (8'(aw_addr))
        pwm_ctrl_pkg::OFS_STATUS: s_axi_bresp <= pwm_ctrl_pkg::RESP_SLVERR;
        default: begin
          s_axi_bresp <= (8'(aw_addr) > pwm_ctrl_pkg::OFS_RESTART)
                         ? pwm_ctrl_pkg::RESP_SLVERR
                         : pwm_ctrl_pkg::RESP_OKAY;
        end
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_period_count    <= pwm_ctrl_pkg::RST_HALF_PERIOD;
      dead_time_count      <= pwm_ctrl_pkg::RST_DEAD_TIME;
      pulse_deletion_count <= pwm_ctrl_pkg::RST_PULSE_DEL;
      sync_width_count     <= pwm_ctrl_pkg::RST_SYNC_WIDTH; // see [R14]
      duty_phase_a         <= pwm_ctrl_pkg::RST_DUTY;
      duty_phase_b         <= pwm_ctrl_pkg::RST_DUTY;
      duty_phase_c         <= pwm_ctrl_pkg::RST_DUTY;
      segment_control      <= pwm_ctrl_pkg::RST_SEGMENT;
      gate_chop_control    <= pwm_ctrl_pkg::RST_GATE_CHOP;
      mode_control_reg     <= pwm_ctrl_pkg::RST_MODE; // see [R11]
    end else if (wr_go) begin
      case (8'(aw_addr))
        pwm_ctrl_pkg::OFS_HALF_PERIOD:
          half_period_count <= CW'(merge(32'(half_period_count),
                                         w_data, w_strb));
        pwm_ctrl_pkg::OFS_DEAD_TIME:
          dead_time_count <= DW'(merge(32'(dead_time_count),
                                       w_data, w_strb));
        pwm_ctrl_pkg::OFS_PULSE_DEL:
          pulse_deletion_count <= CW'(merge(32'(pulse_deletion_count),
                                            w_data, w_strb));
        pwm_ctrl_pkg::OFS_SYNC_WIDTH:
          sync_width_count <= SW'(merge(32'(sync_width_count),
                                        w_data, w_strb)); // see [R13]
        pwm_ctrl_pkg::OFS_DUTY_A:
          duty_phase_a <= CW'(merge(32'(duty_phase_a), w_data, w_strb));
        pwm_ctrl_pkg::OFS_DUTY_B:
          duty_phase_b <= CW'(merge(32'(duty_phase_b), w_data, w_strb));
        pwm_ctrl_pkg::OFS_DUTY_C:
          duty_phase_c <= CW'(merge(32'(duty_phase_c), w_data, w_strb));
        pwm_ctrl_pkg::OFS_SEGMENT:
          segment_control <= 9'(merge(32'(segment_control),
                                      w_data, w_strb));
        pwm_ctrl_pkg::OFS_GATE_CHOP:
          gate_chop_control <= 10'(merge(32'(gate_chop_control),
                                         w_data, w_strb));
        pwm_ctrl_pkg::OFS_MODE:
          mode_control_reg <= 8'(merge(32'(mode_control_reg),
                                       w_data, w_strb)); // see [R10]
        default: begin
        end
      endcase
    end
  end

  // write side effects: shutdown request and restart
  assign soft_shut_wr = wr_go
                        && 8'(aw_addr) == pwm_ctrl_pkg::OFS_SOFT_SHUT;
  assign restart_wr   = wr_go
                        && 8'(aw_addr) == pwm_ctrl_pkg::OFS_RESTART
                        && w_strb[0]
                        && w_data[pwm_ctrl_pkg::RESTART_BIT];

  // ==========================================================
  // axi4-lite read channel, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= pwm_ctrl_pkg::RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= pwm_ctrl_pkg::RESP_OKAY;
      s_axi_rdata   <= '0;
      case (8'(s_axi_araddr))
        pwm_ctrl_pkg::OFS_HALF_PERIOD: s_axi_rdata <= 32'(half_period_count);
        pwm_ctrl_pkg::OFS_DEAD_TIME:   s_axi_rdata <= 32'(dead_time_count);
        pwm_ctrl_pkg::OFS_PULSE_DEL:
          s_axi_rdata <= 32'(pulse_deletion_count);
        pwm_ctrl_pkg::OFS_SYNC_WIDTH:  s_axi_rdata <= 32'(sync_width_count);
        pwm_ctrl_pkg::OFS_DUTY_A:      s_axi_rdata <= 32'(duty_phase_a);
        pwm_ctrl_pkg::OFS_DUTY_B:      s_axi_rdata <= 32'(duty_phase_b);
        pwm_ctrl_pkg::OFS_DUTY_C:      s_axi_rdata <= 32'(duty_phase_c);
        pwm_ctrl_pkg::OFS_SEGMENT:     s_axi_rdata <= 32'(segment_control);
        pwm_ctrl_pkg::OFS_GATE_CHOP:   s_axi_rdata <= 32'(gate_chop_control);
        pwm_ctrl_pkg::OFS_MODE:        s_axi_rdata <= 32'(mode_control_reg);
        pwm_ctrl_pkg::OFS_SOFT_SHUT,
        pwm_ctrl_pkg::OFS_RESTART: begin
        end
        pwm_ctrl_pkg::OFS_STATUS: begin
          // system_status_reg view   see [R20]
          s_axi_rdata[pwm_ctrl_pkg::ST_TRIP_BIT]  <= trip_in_n;
          s_axi_rdata[pwm_ctrl_pkg::ST_SENSE_BIT] <= current_sense_in;
          s_axi_rdata[pwm_ctrl_pkg::ST_SHUT_BIT]  <= shut;
          s_axi_rdata[pwm_ctrl_pkg::ST_HALF_BIT]  <= dir; // see [R21]
        end
        default: s_axi_rresp <= pwm_ctrl_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // shutdown controller
  // comparator output is active high, above the trip level
  assign hw_trip = !trip_in_n || current_sense_in; // see [R16] [R17]

  // set wins over restart; restart ignored while a source is active
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shut <= 1'b0;
    end else if (hw_trip || soft_shut_wr) begin
      shut <= 1'b1; // see [R19] [R23]
    end else if (restart_wr) begin
      shut <= 1'b0; // see [R26]
    end
  end

  // ==========================================================
  // triangle counter, one step per clock   see [R24]
  assign dbl       = mode_control_reg[pwm_ctrl_pkg::MODE_DBL_BIT];
  assign start_evt = (dir == DIR_DOWN) && cnt == '0;
  assign mid_evt   = (dir == DIR_UP)
                     && (17'(cnt) + 17'd1 >= 17'(tm_s));
  assign load_evt  = start_evt || (mid_evt && dbl); // see [R08] [R09]
  assign sync_evt  = load_evt && !shut; // see [R12]

  // each half lasts tm_s clocks   see [R15]
  always_ff @(posedge aclk) begin
    if (!aresetn || shut) begin
      cnt <= '0; // timing unit held in reset   see [R23]
      dir <= DIR_DOWN;
    end else begin
      case (dir)
        DIR_UP: begin
          if (mid_evt) begin
            dir <= DIR_DOWN;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        DIR_DOWN: begin
          if (start_evt) begin
            dir <= DIR_UP;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: dir <= DIR_DOWN;
      endcase
    end
  end

  // shadow settings latched at the update points
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tm_s   <= pwm_ctrl_pkg::RST_HALF_PERIOD;
      dt_s   <= pwm_ctrl_pkg::RST_DEAD_TIME;
      pd_s   <= pwm_ctrl_pkg::RST_PULSE_DEL;
      sw_s   <= pwm_ctrl_pkg::RST_SYNC_WIDTH;
      duty_s <= '{default: pwm_ctrl_pkg::RST_DUTY};
      seg_s  <= pwm_ctrl_pkg::RST_SEGMENT;
    end else if (load_evt) begin
      tm_s      <= half_period_count; // see [R02]
      dt_s      <= dead_time_count;
      pd_s      <= pulse_deletion_count;
      sw_s      <= sync_width_count;
      duty_s[0] <= duty_phase_a; // see [R03]
      duty_s[1] <= duty_phase_b;
      duty_s[2] <= duty_phase_c;
      seg_s     <= segment_control;
    end
  end

  // ==========================================================
  // sync pulse: width+1 clocks from the update point
  always_ff @(posedge aclk) begin
    if (!aresetn || shut) begin
      period_sync_pulse <= 1'b0;
      sync_left         <= '0;
    end else if (sync_evt) begin
      period_sync_pulse <= 1'b1; // see [R14]
      sync_left         <= sync_width_count;
    end else if (sync_left != '0) begin
      sync_left <= sync_left - 1'b1;
    end else begin
      period_sync_pulse <= 1'b0;
    end
  end

  // interrupt requests, one clock each   see [R25]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_irq     <= 1'b0;
      shutdown_irq <= 1'b0;
      shut_q       <= 1'b0;
    end else begin
      sync_irq     <= sync_evt;
      shut_q       <= shut;
      shutdown_irq <= shut && !shut_q;
    end
  end

  // ==========================================================
  // gate chopping: toggles every (field+1) clocks   see [R06]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chop_cnt <= '0;
      chop     <= 1'b0;
    end else if (chop_cnt >= gate_chop_control[7:0]) begin
      chop_cnt <= '0;
      chop     <= !chop;
    end else begin
      chop_cnt <= chop_cnt + 1'b1;
    end
  end

  // ==========================================================
  // per-phase timing and output steering
  for (genvar p = 0; p < 3; p++) begin : g_phase
    pwm_phase_channel #(
      .CNT_W (CW),
      .DT_W  (DW)
    ) u_chan (
      .cnt         (cnt),
      .half_period (tm_s),
      .dead_time   (dt_s),
      .min_width   (pd_s),
      .duty        (duty_s[p]),
      .hi_on       (hi_t[p]),
      .lo_on       (lo_t[p])
    );
    // crossover swaps the pair   see [R05]
    assign pwm_raw[2*p]   = seg_s[pwm_ctrl_pkg::SEG_XOVER_LSB+p]
                            ? lo_t[p] : hi_t[p];
    assign pwm_raw[2*p+1] = seg_s[pwm_ctrl_pkg::SEG_XOVER_LSB+p]
                            ? hi_t[p] : lo_t[p];
    // enable gates, then optional chopping per side   see [R04] [R07]
    assign next_out[2*p]   = pwm_raw[2*p] && seg_s[2*p]
      && (!gate_chop_control[pwm_ctrl_pkg::CHOP_HI_BIT] || chop);
    assign next_out[2*p+1] = pwm_raw[2*p+1] && seg_s[2*p+1]
      && (!gate_chop_control[pwm_ctrl_pkg::CHOP_LO_BIT] || chop);
  end

  // output flops cleared at once by a hardware trip, clock or not
  always_ff @(posedge aclk or posedge hw_trip) begin
    if (hw_trip) begin
      phase_a_high_out <= 1'b0; // see [R16] [R17] [R18]
      phase_a_low_out  <= 1'b0;
      phase_b_high_out <= 1'b0;
      phase_b_low_out  <= 1'b0;
      phase_c_high_out <= 1'b0;
      phase_c_low_out  <= 1'b0;
    end else if (!aresetn || shut) begin
      phase_a_high_out <= 1'b0; // see [R19] [R26]
      phase_a_low_out  <= 1'b0;
      phase_b_high_out <= 1'b0;
      phase_b_low_out  <= 1'b0;
      phase_c_high_out <= 1'b0;
      phase_c_low_out  <= 1'b0;
    end else begin
      phase_a_high_out <= next_out[0]; // see [R01]
      phase_a_low_out  <= next_out[1];
      phase_b_high_out <= next_out[2];
      phase_b_low_out  <= next_out[3];
      phase_c_high_out <= next_out[4];
      phase_c_low_out  <= next_out[5];
    end
  end

endmodule : pwm_three_phase
`default_nettype wire

// ### pwm_ctrl_pkg.sv
// constants for the three-phase pwm controller: register map, fields,
// reset values and bus answers. assumes a 32-bit axi4-lite register bus.
package pwm_ctrl_pkg;

  // ==========================================================
  // widths
  localparam int CNT_W  = 16;
  localparam int DT_W   = 10;
  localparam int SW_W   = 8;
  localparam int CHOP_W = 8;
  localparam int SEG_W  = 9;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_HALF_PERIOD = 8'h00;
  localparam logic [7:0] OFS_DEAD_TIME   = 8'h04;
  localparam logic [7:0] OFS_PULSE_DEL   = 8'h08;
  localparam logic [7:0] OFS_SYNC_WIDTH  = 8'h0C;
  localparam logic [7:0] OFS_DUTY_A      = 8'h10;
  localparam logic [7:0] OFS_DUTY_B      = 8'h14;
  localparam logic [7:0] OFS_DUTY_C      = 8'h18;
  localparam logic [7:0] OFS_SEGMENT     = 8'h1C;
  localparam logic [7:0] OFS_GATE_CHOP   = 8'h20;
  localparam logic [7:0] OFS_MODE        = 8'h24;
  localparam logic [7:0] OFS_SOFT_SHUT   = 8'h28;
  localparam logic [7:0] OFS_STATUS      = 8'h2C;
  localparam logic [7:0] OFS_RESTART     = 8'h30;

  // ==========================================================
  // field positions
  localparam int SEG_EN_LSB    = 0;  // six enables, ah al bh bl ch cl
  localparam int SEG_XOVER_LSB = 6;  // three crossover bits, a b c
  localparam int CHOP_HI_BIT   = 8;
  localparam int CHOP_LO_BIT   = 9;
  localparam int MODE_DBL_BIT  = 6;
  localparam int ST_TRIP_BIT   = 0;
  localparam int ST_SENSE_BIT  = 1;
  localparam int ST_SHUT_BIT   = 2;
  localparam int ST_HALF_BIT   = 3;
  localparam int RESTART_BIT   = 0;

  // ==========================================================
  // reset values
  localparam logic [CNT_W-1:0] RST_HALF_PERIOD = 16'h0000;
  localparam logic [DT_W-1:0]  RST_DEAD_TIME   = 10'h000;
  localparam logic [CNT_W-1:0] RST_PULSE_DEL   = 16'h0000;
  localparam logic [SW_W-1:0]  RST_SYNC_WIDTH  = 8'h27;
  localparam logic [CNT_W-1:0] RST_DUTY        = 16'h0000;
  localparam logic [SEG_W-1:0] RST_SEGMENT     = 9'h03F;
  localparam logic [9:0]       RST_GATE_CHOP   = 10'h000;
  localparam logic [7:0]       RST_MODE        = 8'h00;

  // ==========================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pwm_ctrl_pkg

// ### pwm_phase_channel.sv
// one phase of the timing unit: center-based high/low timing with dead
// time and narrow pulse deletion. assumes a triangle count from the top.
`timescale 1ns/100ps
`default_nettype none
module pwm_phase_channel #(
  parameter int CNT_W = 16,
  parameter int DT_W  = 10
) (
  // triangle count and latched settings
  input  wire logic [CNT_W-1:0] cnt,
  input  wire logic [CNT_W-1:0] half_period,
  input  wire logic [DT_W-1:0]  dead_time,
  input  wire logic [CNT_W-1:0] min_width,
  input  wire logic [CNT_W-1:0] duty,
  // timing signals before output steering
  output logic                  hi_on,
  output logic                  lo_on
);

  logic [CNT_W+1:0] edge_pt;
  logic [CNT_W+1:0] hi_w;
  logic [CNT_W+1:0] lo_w;
  logic [CNT_W+1:0] dtx;

  // edges sit dt either side of the nominal edge, gap is 2*dt
  always_comb begin
    dtx = (CNT_W+2)'(dead_time);
    if (duty > half_period) begin
      edge_pt = '0;
    end else begin
      edge_pt = (CNT_W+2)'(half_period - duty);
    end
    hi_w = (CNT_W+2)'(half_period) - edge_pt;
    lo_w = edge_pt;
    hi_w = (hi_w > dtx) ? hi_w - dtx : '0;
    lo_w = (lo_w > dtx) ? lo_w - dtx : '0;
    // pulses narrower than the minimum width are dropped   see [R02]
    hi_on = ((CNT_W+2)'(cnt) >= edge_pt + dtx)
            && (hi_w >= (CNT_W+2)'(min_width)); // see [R22]
    lo_on = ((CNT_W+2)'(cnt) + dtx < edge_pt)
            && (lo_w >= (CNT_W+2)'(min_width)); // see [R22]
  end

endmodule : pwm_phase_channel
`default_nettype wire

// ### gate_drive_model.sv
// gate driver stand-in: records which drives fired since a clear
// assumes g is {cl,ch,bl,bh,al,ah} on the controller clock
`timescale 1ns/100ps
`default_nettype none
module gate_drive_model (
  // clock and record clear
  input  wire logic       aclk,
  input  wire logic       clr,
  // six gate drives in, record out
  input  wire logic [5:0] g,
  output logic      [5:0] seen
);
  // sticky: a driver only cares that a gate ever fired
  always_ff @(posedge aclk) begin
    seen <= clr ? 6'h00 : seen | g;
  end
endmodule : gate_drive_model
`default_nettype wire

// ### pwm_three_phase_sva.sv
// port checker for the pwm controller
// bound to pwm_three_phase, sees its ports only
`timescale 1ns/100ps
`default_nettype none
module pwm_sva (
  // clock, reset, trips
  input wire logic aclk, aresetn, trip_in_n, current_sense_in,
  // bus handshakes
  input wire logic s_axi_bvalid, s_axi_bready,
  input wire logic s_axi_rvalid, s_axi_arready,
  // drives, sync and interrupts
  input wire logic phase_a_high_out, phase_a_low_out,
  input wire logic phase_b_high_out, phase_b_low_out,
  input wire logic phase_c_high_out, phase_c_low_out,
  input wire logic period_sync_pulse, sync_irq, shutdown_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a trip held for three samples must have latched shutdown
  sequence s_trip; !trip_in_n [*3]; endsequence
  sequence s_sense; current_sense_in [*3]; endsequence
  a_trip_off: assert property (
    !trip_in_n |-> !(phase_a_high_out |
    phase_a_low_out | phase_b_high_out | phase_b_low_out |
    phase_c_high_out | phase_c_low_out)) else $error("drive on in trip");
  a_sense_off: assert property (
    current_sense_in |-> !(phase_a_high_out |
    phase_a_low_out | phase_b_high_out | phase_b_low_out |
    phase_c_high_out | phase_c_low_out)) else $error("drive on in sense");
  a_pair_excl: assert property (
    !(phase_a_high_out & phase_a_low_out) &&
    !(phase_b_high_out & phase_b_low_out) &&
    !(phase_c_high_out & phase_c_low_out)) else $error("pair overlap");
  a_trip_nosync: assert property (
    s_trip |-> !$rose(period_sync_pulse)) else $error("sync while tripped");
  a_sense_nosync: assert property (
    s_sense |-> !$rose(period_sync_pulse)) else $error("sync while sensed");
  // a sync event inside a still-high pulse retriggers it without a rise
  a_sync_irq: assert property (
    ($rose(period_sync_pulse) |-> sync_irq) and
    (sync_irq |-> period_sync_pulse)) else $error("sync irq mismatch");
  a_shut_pulse: assert property (shutdown_irq |=> !shutdown_irq)
    else $error("shutdown irq long");
  a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
endmodule : pwm_sva
bind pwm_three_phase pwm_sva u_sva (.*);
`default_nettype wire

// ### pwm_three_phase_tb.sv
// bench for pwm_three_phase: axi4-lite tasks, sync timing, shutdowns
// assumes the checker is bound and the gate model sits on the drives
`timescale 1ns/100ps
`default_nettype none
module pwm_three_phase_tb;
  logic aclk = 0, aresetn = 0, trip_in_n = 1, current_sense_in = 0, clr = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, period_sync_pulse;
  logic phase_a_high_out, phase_a_low_out, phase_b_high_out;
  logic phase_b_low_out, phase_c_high_out, phase_c_low_out;
  logic sync_irq, shutdown_irq, pa, pw;
  logic [5:0] seen, g;
  int n_fail = 0, compares = 0, w, l, k;
  assign g = {phase_c_low_out, phase_c_high_out, phase_b_low_out,
              phase_b_high_out, phase_a_low_out, phase_a_high_out};
  always #20 aclk = ~aclk;
  pwm_three_phase uut (.*);
  gate_drive_model gdm (.aclk(aclk), .clr(clr), .g(g), .seen(seen));
  task results;
    $display("n_fail=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // every wait is bounded; running out ends the run as a mismatch
  task rdy(input int s);
    int i;
    i = 0;
    do begin @(negedge aclk); i++; end
    while (!(s == 0 ? s_axi_bvalid : s == 1 ? s_axi_arready :
           s == 2 ? s_axi_rvalid : period_sync_pulse === s[0]) && i < 999);
    if (i >= 999) begin n_fail++; results(); end
    w = i;
  endtask : rdy
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    pa = 1;
    pw = 1;
    for (k = 0; k < 99 && (pa | pw); k++) begin
      @(negedge aclk);
      if (s_axi_awready) pa = 0;
      if (s_axi_wready) pw = 0;
      @(posedge aclk);
      if (!pa) s_axi_awvalid <= 0;
      if (!pw) s_axi_wvalid <= 0;
    end
    rdy(0);
    r = s_axi_bresp;
    @(posedge aclk) s_axi_bready <= 0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    rdy(1);
    @(posedge aclk) s_axi_arvalid <= 0;
    rdy(2);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    @(posedge aclk) s_axi_rready <= 0;
  endtask : rd
  // waits three sync rises: l = second rise to third, w = second pulse width
  task sy;
    rdy(33); repeat (2) begin rdy(32); l = w; rdy(33); l += w; w = l - w; end
  endtask : sy
  task cl(input int n);
    @(posedge aclk) clr <= 1;
    @(posedge aclk) clr <= 0;
    repeat (n) @(negedge aclk);
  endtask : cl
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(8'h0C); chk(d, 32'h27);
    rd(8'h24); chk(d, 32'h0);
    rd(8'h2C); chk(d & 32'h1, 32'h1);
    rd(8'h40); chk(r, 32'h2);
    wr(8'h2C, 32'h0); chk(r, 32'h2);
    $display("registers done");
    wr(8'h00, 32'd20); wr(8'h04, 32'd2);
    wr(8'h0C, 32'd3);
    for (int q = 0; q < 3; q++) wr(8'h10 + 8'(4 * q), 32'd10);
    wr(8'h30, 32'h1); sy;
    chk(w, 32'd4); chk(l, 32'd40);
    rd(8'h2C); chk(d & 32'h8, 32'h0);
    cl(45); chk(seen, 6'h3F);
    wr(8'h1C, 32'h15); repeat (90) @(negedge aclk);
    cl(45); chk(seen, 6'h15);
    wr(8'h1C, 32'h3F); wr(8'h24, 32'h40);
    sy; chk(l, 32'd20);
    wr(8'h24, 32'h0); sy; chk(l, 32'd40);
    $display("waveforms done");
    for (int t = 0; t < 3; t++) begin
      if (t == 2) wr(8'h28, 32'h1);
      @(posedge aclk) {current_sense_in, trip_in_n} <= {t == 1, t != 0};
      @(negedge aclk) chk(g, 6'h00);
      rd(8'h2C); chk(d & 32'h4, 32'h4);
      @(posedge aclk) {current_sense_in, trip_in_n} <= 2'h1;
      cl(60); chk(seen, 6'h00);
      wr(8'h30, 32'h1); sy; chk(l, 32'd40);
    end
    $display("shutdowns done");
    results();
  end
endmodule : pwm_three_phase_tb
`default_nettype wire
